// File: design/odt_latency_timing.sv
// Purpose: termination latency timing of a ddr3 device
// Assumes: inputs already on sys_clk_in; wl between 5 and 15
// Notes:   pipelines delay the pin by wl-2 cycles
// Contract
// - termination turns on wl-2 after registered high
// - termination turns off wl-2 after registered low
// - write switches to write termination after wl-2
// - chopped write returns to nominal by 4+off
// - full write returns to nominal by 6+off
// - write recovery is programmed cycle value
`timescale 1ns/100ps
`include "odt_map.svh"
module odt_latency_timing
  import odt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // configuration from mode registers
  input  wire logic [3:0] write_latency_cycles_in,
  input  wire logic [2:0] nominal_termination_in,
  input  wire logic [1:0] write_termination_in,
  input  wire logic [4:0] write_recovery_cycles_in,
  // pins
  input  wire logic       termination_input_in,
  input  wire logic       write_cmd_in,
  input  wire logic       write_chop_in,
  // termination state and advisory counts
  output odt_term_e       term_state_out,
  output logic [4:0]      write_to_powerdown_delay_out,
  output logic [3:0]      term_powerdown_latency_out
);
  ////////////////////////////////////////////////////////////////////////
  localparam int D = `ODT_PIPE_DEPTH;
  logic [D-1:0] odt_pipe_ff;
  logic [D-1:0] wr_pipe_ff;
  logic [4:0]   wr_hold_ff;
  odt_term_e    state_ff;
  logic [4:0]   wtpd_ff;
  logic [3:0]   tpd_ff;

  wire [3:0] lat = write_latency_cycles_in - `ODT_LAT_SUB;
  wire [3:0] tap = lat - 4'h1;
  // index lat-1: input registered at shift 0, so lat edges later
  wire       odt_dly = odt_pipe_ff[tap];
  wire       wr_dly  = wr_pipe_ff[tap];
  wire       wr_en   = write_termination_in != `ODT_WR_OFF;
  // chop flag travels with write; hold measured from delayed write
  logic [D-1:0] chop_pipe_ff;
  wire       chop_dly = chop_pipe_ff[tap];
  wire [4:0] hold_dly = chop_dly ? `ODT_CHOP_EXTRA : `ODT_FULL_EXTRA;
  wire       nom_on  = nominal_termination_in != `ODT_RTT_OFF;
  wire       in_wr   = wr_hold_ff != 5'h00;
  odt_term_e nxt_state;
  assign nxt_state = !odt_dly ? ODT_HIZ :
                     (wr_en && (wr_dly || in_wr)) ? ODT_WRT :
                     nom_on ? ODT_NOM : ODT_HIZ;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      odt_pipe_ff  <= '0;
      wr_pipe_ff   <= '0;
      chop_pipe_ff <= '0;
    end else begin
      odt_pipe_ff  <= {odt_pipe_ff[D-2:0], termination_input_in};
      wr_pipe_ff   <= {wr_pipe_ff[D-2:0], write_cmd_in};
      chop_pipe_ff <= {chop_pipe_ff[D-2:0], write_chop_in};
    end
  end

  // write window: hold counts from delayed write, ends by 4 or 6 more
  always_ff @(posedge sys_clk_in) begin
    if (rst_in)
      wr_hold_ff <= 5'h00;
    else if (wr_dly)
      wr_hold_ff <= hold_dly - 5'h01;
    else if (in_wr)
      wr_hold_ff <= wr_hold_ff - 5'h01;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in)
      state_ff <= ODT_HIZ;
    else
      state_ff <= nxt_state;
  end

  // advisory counts for the controller side, kept in cycles
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wtpd_ff <= 5'h00;
      tpd_ff  <= 4'h0;
    end else begin
      wtpd_ff <= write_recovery_cycles_in;
      tpd_ff  <= write_latency_cycles_in - `ODT_PD_SUB;
    end
  end

  assign term_state_out               = state_ff;
  assign write_to_powerdown_delay_out = wtpd_ff;
  assign term_powerdown_latency_out   = tpd_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks look one edge past the delayed taps: the state register is
  // loaded from them, so each latency below is exactly wl-1 from the pin.
  // the hold counter is checked by its window length, and its value only by a range bound,
  // so a wrong reload would show up as a state that ends too early or overstays.

  sequence s_term_seen;
    odt_dly && nom_on;
  endsequence

  sequence s_plain_on;
    odt_dly && nom_on && !wr_dly && !in_wr;
  endsequence

  sequence s_quiet;
    odt_dly && !wr_dly;
  endsequence

  sequence s_chop_wr;
    wr_dly && chop_dly;
  endsequence

  sequence s_full_wr;
    wr_dly && !chop_dly;
  endsequence

  sequence s_chop_on;
    odt_dly && wr_en && wr_dly && chop_dly;
  endsequence

  sequence s_full_on;
    odt_dly && wr_en && wr_dly && !chop_dly;
  endsequence

  chk_turn_on_delay: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_term_seen |=> state_ff != ODT_HIZ)
    else $error("termination not on after latency");

  chk_nominal_level: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_plain_on |=> state_ff == ODT_NOM)
    else $error("nominal termination not applied");

  chk_turn_off_delay: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !odt_dly |=> state_ff == ODT_HIZ)
    else $error("termination not off after latency");

  // no disable here: reset itself must leave the pins unterminated
  chk_reset_hiz: assert property (
    @(posedge sys_clk_in)
    rst_in |=> state_ff == ODT_HIZ)
    else $error("termination active out of reset");

  chk_write_switch: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    odt_dly && wr_dly && wr_en |=> state_ff == ODT_WRT)
    else $error("write termination not applied");

  chk_write_only_late: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !wr_dly && !in_wr |=> state_ff != ODT_WRT)
    else $error("write termination without delayed write");

  chk_chop_hold: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_chop_on ##1 s_quiet[*3] |=> state_ff == ODT_WRT)
    else $error("chopped write window ends early");

  chk_chop_return: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_chop_wr ##1 !wr_dly[*4] |=> state_ff != ODT_WRT)
    else $error("chopped write overstays");

  chk_full_hold: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_full_on ##1 s_quiet[*5] |=> state_ff == ODT_WRT)
    else $error("full write window ends early");

  chk_full_return: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_full_wr ##1 !wr_dly[*6] |=> state_ff != ODT_WRT)
    else $error("full write overstays");

  // counter never reloads beyond the long window
  chk_hold_range: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    in_wr |-> wr_hold_ff < `ODT_FULL_EXTRA)
    else $error("write window counter out of range");

  chk_no_wr_term: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !wr_en |=> state_ff != ODT_WRT)
    else $error("write termination while unprogrammed");

  chk_nom_in_write: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    odt_dly && nom_on && !wr_en |=> state_ff == ODT_NOM)
    else $error("nominal termination dropped during write");

  chk_wr_recovery: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    $stable(write_recovery_cycles_in) |=>
    write_to_powerdown_delay_out == write_recovery_cycles_in)
    else $error("write recovery not the programmed value");

  chk_pd_latency: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    $stable(write_latency_cycles_in) |=>
    term_powerdown_latency_out == write_latency_cycles_in - 4'h1)
    else $error("power-down latency wrong");

  chk_out_reset: assert property (
    @(posedge sys_clk_in)
    rst_in |=> write_to_powerdown_delay_out == 5'h00 &&
    term_powerdown_latency_out == 4'h0)
    else $error("advisory counts not cleared by reset");
endmodule // odt_latency_timing

// File: design/odt_map.svh
// Purpose: constants for the termination latency block
// Assumes: latencies counted in clock cycles of sys_clk_in
// Notes:   write latency comes in as a port value
`ifndef ODT_MAP_SVH
`define ODT_MAP_SVH
`define ODT_LAT_SUB        4'h2
`define ODT_PD_SUB         4'h1
`define ODT_CHOP_EXTRA     5'h04
`define ODT_FULL_EXTRA     5'h06
`define ODT_RTT_OFF        3'h0
`define ODT_WR_OFF         2'h0
`define ODT_PIPE_DEPTH     16
`endif

// File: design/odt_pkg.sv
// Purpose: types for the termination latency block
// Assumes: none
// Notes:   termination state of the data pins
package odt_pkg;
  typedef enum logic [1:0] {
    ODT_HIZ   = 2'h0,
    ODT_NOM   = 2'h1,
    ODT_WRT   = 2'h3
  } odt_term_e;
endpackage

// File: tb/odt_ctrl_model.sv
// Purpose: controller side driving termination and writes
// Assumes: outputs move on the falling edge
// Notes:   fixed high span, one write in its second cycle
`timescale 1ns/100ps
module odt_ctrl_model (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic chop_in,
  output logic      term_out,
  output logic      wr_out,
  output logic      chop_out
);
  logic [3:0] cnt_ff = 4'h0;
  // ten cycles high covers the long write minimum
  always @(negedge clk_in) begin
    if (go_in) cnt_ff <= 4'h1;
    else if (cnt_ff != 4'h0 && cnt_ff < 4'ha) cnt_ff <= cnt_ff + 4'h1;
    else cnt_ff <= 4'h0;
  end
  // dll taken as locked: only synchronous termination is driven
  assign term_out = (cnt_ff != 4'h0);
  assign wr_out   = (cnt_ff == 4'h2);
  assign chop_out = wr_out & chop_in;
endmodule // odt_ctrl_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the termination latency block
// Assumes: configuration changes only under reset
// Notes:   each state change is matched to a noted cycle and value
`timescale 1ns/100ps
module testbench;
  import odt_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] wl = 4'h5;
  logic [2:0] nom = 3'h1;
  logic [1:0] wrt = 2'h1;
  logic [4:0] wr_rec = 5'h0;
  logic go = 1'b0, chop = 1'b0, term, wr, wchop;
  odt_term_e state, last = ODT_HIZ;
  logic [4:0] pd_dly;
  logic [3:0] pd_lat;
  int errors = 0, samples_checked = 0, cyc = 0, seed = 83497, k, lat;
  int wr_ns;
  int qc[$];
  logic [1:0] qv[$];
  // run is far shorter than any refresh interval: no refresh falls due
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  odt_ctrl_model ctrl_u (.clk_in(sys_clk_in), .go_in(go), .chop_in(chop),
    .term_out(term), .wr_out(wr), .chop_out(wchop));
  odt_latency_timing dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .write_latency_cycles_in(wl), .nominal_termination_in(nom),
    .write_termination_in(wrt), .write_recovery_cycles_in(wr_rec),
    .termination_input_in(term), .write_cmd_in(wr), .write_chop_in(wchop),
    .term_state_out(state), .write_to_powerdown_delay_out(pd_dly),
    .term_powerdown_latency_out(pd_lat));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic note(input int c, input logic [1:0] v);
    qc.push_back(c);
    qv.push_back(v);
  endtask
  task automatic test_done;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk_in) if (!rst_in && state !== last) begin
    check(qc.size() ? qc.pop_front() : -1, cyc);
    check(qv.size() ? qv.pop_front() : 2'h2, state);
    last = state;
  end
  initial begin
    for (int r = 0; r < 6; r++) begin
      rst_in = 1'b1;
      wl = 4'h5 + 4'({$random(seed)} % 11);
      nom = 3'h1 + 3'({$random(seed)} % 7);
      wrt = (r == 2) ? 2'h0 : 2'h1 + 2'({$random(seed)} % 3);
      wr_ns = 15 + {$random(seed)} % 600;
      wr_rec = 5'((wr_ns + 39) / 40);
      chop = r[0];
      repeat (10) @(negedge sys_clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      check(pd_dly, wr_rec);
      check(pd_lat, wl - 4'h1);
      k = cyc;
      lat = wl - 2;
      go <= 1'b1;
      note(k + 2 + lat, ODT_NOM);
      if (wrt != 2'h0) begin
        note(k + 3 + lat, ODT_WRT);
        note(k + 3 + lat + (chop ? 4 : 6), ODT_NOM);
      end
      note(k + 12 + lat, ODT_HIZ);
      @(negedge sys_clk_in);
      go <= 1'b0;
      repeat (30) @(negedge sys_clk_in);
      check(qc.size(), 0);
    end
    test_done();
  end
  // six runs of about 44 cycles each, with ample margin
  initial begin
    #20000;
    errors++;
    test_done();
  end
endmodule // testbench
